// ===== crs_pix_buf.sv
// Two-entry pixel buffer between the digitizer and the receiver
module crs_pix_buf (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire crs_pkg::crs_pix_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output crs_pkg::crs_pix_t out_data
);
    crs_pkg::crs_pix_t mem_ff [2];
    logic [1:0] cnt_ff;
    logic wr_ff;
    logic rd_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != crs_pkg::BUF_DEPTH);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_entry
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_ff[g] <= '0;
                end else if (clk_en && push && wr_ff == 1'(g)) begin
                    mem_ff[g] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_ff <= ~wr_ff;
            end
            if (pop) begin
                rd_ff <= ~rd_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
endmodule

// ===== crs_pkg.sv
// Shared constants and types of the CCD readout sequencer
package crs_pkg;
    // Array size is a build choice; counters allow up to 2047
    localparam logic [10:0] SENSOR_COLS = 11'h020;
    localparam logic [10:0] SENSOR_ROWS = 11'h020;
    localparam logic [10:0] HALF_COLS = 11'h010;
    localparam logic [10:0] COL_ONE = 11'h001;
    localparam logic SINGLE_PORT_SEL = 1'b0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [15:0] CYC_ZERO = 16'h0000;
    localparam logic [23:0] EXP_ZERO = 24'h000000;

    typedef enum logic [2:0] {
        RO_IDLE = 3'h0,
        RO_XFER = 3'h1,
        RO_ROW = 3'h2,
        RO_PIX = 3'h3,
        RO_DIG = 3'h4,
        RO_DONE = 3'h5
    } crs_ro_state_t;

    typedef enum logic [1:0] {
        EX_ARM = 2'h0,
        EX_GATE = 2'h1,
        EX_DECAY = 2'h2,
        EX_HAND = 2'h3
    } crs_ex_state_t;

    typedef struct packed {
        logic en;
        logic [10:0] col_start;
        logic [10:0] col_count;
        logic [10:0] row_start;
        logic [10:0] row_count;
    } crs_roi_t;

    typedef struct packed {
        logic [7:0] pixel_shift_duration;
        logic [7:0] digitize;
        logic [7:0] row_shift;
        logic [23:0] exposure;
        logic [15:0] decay;
    } crs_timing_t;

    typedef struct packed {
        logic sof;
        logic eof;
        logic [15:0] sample_a;
        logic [15:0] sample_b;
    } crs_pix_t;
endpackage

// ===== crs_sensor_model.sv
// Behavioural sensor digitizer and stalling pixel receiver facing the sequencer
module crs_sensor_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pixel_digitize,
    input wire logic dual,
    input wire logic stall,
    input wire logic pix_valid,
    input wire crs_pkg::crs_pix_t pix_data,
    output logic pix_ready,
    output logic [15:0] adc_sample_a,
    output logic [15:0] adc_sample_b,
    output logic [31:0] words,
    output logic [31:0] sof_seen,
    output logic [31:0] eof_seen,
    output logic [31:0] bad_words
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dig_q;
    logic [1:0] phase;
    // Port B carries the inverse, so swapped or missing halves show up
    assign adc_sample_b = ~adc_sample_a;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dig_q <= 1'b0;
            phase <= 2'h0;
            pix_ready <= 1'b0;
            adc_sample_a <= 16'h0000;
            words <= 32'h00000000;
            sof_seen <= 32'h00000000;
            eof_seen <= 32'h00000000;
            bad_words <= 32'h00000000;
        end else begin
            dig_q <= pixel_digitize;
            // Fresh charge value per conversion, advanced only after the push
            if (dig_q && !pixel_digitize) begin
                adc_sample_a <= adc_sample_a + 16'h0001;
            end
            phase <= phase + 2'h1;
            // Receiver takes one word in four cycles while stalling
            pix_ready <= !stall || (phase == 2'h3);
            if (pix_valid && pix_ready) begin
                words <= words + 32'h00000001;
                sof_seen <= sof_seen + 32'(pix_data.sof);
                eof_seen <= eof_seen + 32'(pix_data.eof);
                if (pix_data.sample_a !== words[15:0] ||
                    pix_data.sample_b !== (dual ? ~words[15:0] : 16'h0000)) begin
                    bad_words <= bad_words + 32'h00000001;
                end
            end
        end
    end
endmodule

// ===== crs_sequencer.sv
// Exposure and readout sequencer for an intensified CCD
module crs_sequencer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic acq_enable,
    input wire logic free_run,
    input wire logic ext_sync,
    input wire logic sensor_interline,
    input wire logic variant_single_port,
    input wire crs_pkg::crs_roi_t roi,
    input wire crs_pkg::crs_timing_t timing,
    input wire logic [15:0] adc_sample_a,
    input wire logic [15:0] adc_sample_b,
    output logic intensifier_gate,
    output logic storage_xfer,
    output logic row_shift,
    output logic pixel_shift,
    output logic pixel_digitize,
    output logic dual_port_active,
    output logic single_port_sel,
    output logic overlapped_mode,
    output logic frame_done,
    output logic [31:0] readout_cycles,
    output logic [31:0] frame_cycles,
    output logic pix_valid,
    input wire logic pix_ready,
    output crs_pkg::crs_pix_t pix_data
);
    crs_pkg::crs_ro_state_t ro_ff;
    crs_pkg::crs_ex_state_t ex_ff;
    crs_pkg::crs_roi_t roi_ff;
    crs_pkg::crs_pix_t push_word;
    logic [15:0] cyc_ff;
    logic [23:0] ex_cyc_ff;
    logic [10:0] col_ff;
    logic [10:0] row_ff;
    logic dual_ff;
    logic intl_ff;
    logic ovl_ff;
    logic sof_ff;
    logic sync_pend_ff;
    logic [31:0] readout_cycles_ff;
    logic [31:0] frame_cycles_ff;
    logic dual_ok;
    logic [10:0] eff_cols;
    logic [10:0] eff_rows;
    logic [21:0] eff_pix;
    logic [31:0] nxt_readout;
    logic nxt_ovl;
    logic ex_permit;
    logic ex_go;
    logic ro_start;
    logic [15:0] ro_limit;
    logic ro_tick;
    logic ro_step;
    logic buf_in_ready;
    logic [11:0] col_end;
    logic [11:0] row_end;
    logic col_hit;
    logic row_hit;
    logic px_hit;
    logic col_last;
    logic row_last;
    logic roi_last;
    logic push;
    crs_pkg::crs_ro_state_t nxt_after;

    // Centred means equal margins on both sides; binning plays no part
    assign col_end = {1'b0, roi.col_start} + {1'b0, roi.col_count};
    assign dual_ok = !variant_single_port
        && (!roi.en || roi.col_start == crs_pkg::SENSOR_COLS - col_end[10:0]);

    // Estimate per port: dual halves the columns each port carries
    assign eff_cols = roi.en ? roi.col_count : crs_pkg::SENSOR_COLS;
    assign eff_rows = roi.en ? roi.row_count : crs_pkg::SENSOR_ROWS;
    assign eff_pix = (dual_ok ? {1'b0, eff_cols[10:1]} : eff_cols) * eff_rows;
    // Widen before multiplying so a full array cannot wrap the product
    assign nxt_readout = 32'(eff_pix) * (32'(timing.pixel_shift_duration) + 32'(timing.digitize))
        + 32'(eff_rows) * 32'(timing.row_shift);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readout_cycles_ff <= 32'h0;
            frame_cycles_ff <= 32'h0;
        end else if (clk_en) begin
            readout_cycles_ff <= nxt_readout;
            frame_cycles_ff <= readout_cycles_ff + {8'h0, timing.exposure} + {16'h0, timing.decay};
        end
    end
    assign readout_cycles = readout_cycles_ff;
    assign frame_cycles = frame_cycles_ff;

    // Only interline parts hold a frame in storage, so only they can overlap
    assign nxt_ovl = sensor_interline && !({8'h0, timing.exposure} < readout_cycles_ff);
    // Non-overlapped waits for the frame-done return to idle
    assign ex_permit = nxt_ovl ? (ro_ff != crs_pkg::RO_XFER) : (ro_ff == crs_pkg::RO_IDLE);
    assign ex_go = ex_ff == crs_pkg::EX_ARM && acq_enable && (free_run || sync_pend_ff || ext_sync)
        && ex_permit;
    assign ro_start = ex_ff == crs_pkg::EX_HAND && ro_ff == crs_pkg::RO_IDLE;

    // A sync seen while armed but not yet permitted to start is held; one seen during an exposure is dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_pend_ff <= 1'b0;
        end else if (clk_en) begin
            if (ext_sync && ex_ff == crs_pkg::EX_ARM && !ex_go) begin
                sync_pend_ff <= 1'b1;
            end else if (ex_go) begin
                sync_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ex_ff <= crs_pkg::EX_ARM;
            ex_cyc_ff <= crs_pkg::EXP_ZERO;
            ovl_ff <= 1'b0;
        end else if (clk_en) begin
            case (ex_ff)
                crs_pkg::EX_ARM: begin
                    ex_cyc_ff <= crs_pkg::EXP_ZERO;
                    if (ex_go) begin
                        ovl_ff <= nxt_ovl;
                        ex_ff <= crs_pkg::EX_GATE;
                    end
                end
                crs_pkg::EX_GATE: begin
                    if (ex_cyc_ff + 24'h1 >= timing.exposure) begin
                        ex_cyc_ff <= crs_pkg::EXP_ZERO;
                        ex_ff <= crs_pkg::EX_DECAY;
                    end else begin
                        ex_cyc_ff <= ex_cyc_ff + 24'h1;
                    end
                end
                crs_pkg::EX_DECAY: begin
                    if (ex_cyc_ff + 24'h1 >= {8'h0, timing.decay}) begin
                        ex_ff <= crs_pkg::EX_HAND;
                    end else begin
                        ex_cyc_ff <= ex_cyc_ff + 24'h1;
                    end
                end
                crs_pkg::EX_HAND: begin
                    if (ro_start) begin
                        ex_ff <= crs_pkg::EX_ARM;
                    end
                end
                default: ex_ff <= crs_pkg::EX_ARM;
            endcase
        end
    end

    localparam logic [15:0] CYC_ONE_LIMIT = 16'h0001;
    always_comb begin
        case (ro_ff)
            crs_pkg::RO_XFER, crs_pkg::RO_ROW: ro_limit = {8'h0, timing.row_shift};
            crs_pkg::RO_PIX: ro_limit = {8'h0, timing.pixel_shift_duration};
            crs_pkg::RO_DIG: ro_limit = {8'h0, timing.digitize};
            default: ro_limit = CYC_ONE_LIMIT;
        endcase
    end
    assign ro_tick = cyc_ff + 16'h1 >= ro_limit;
    assign ro_step = ro_tick && (ro_ff == crs_pkg::RO_PIX || (ro_ff == crs_pkg::RO_DIG && buf_in_ready));

    assign row_end = {1'b0, roi_ff.row_start} + {1'b0, roi_ff.row_count};
    assign col_hit = !roi_ff.en || (col_ff >= roi_ff.col_start
        && (dual_ff || {1'b0, col_ff} < {1'b0, roi_ff.col_start} + {1'b0, roi_ff.col_count}));
    assign row_hit = !roi_ff.en || (row_ff >= roi_ff.row_start && {1'b0, row_ff} < row_end);
    assign px_hit = col_hit && row_hit;
    assign col_last = col_ff == (dual_ff ? crs_pkg::HALF_COLS : crs_pkg::SENSOR_COLS) - crs_pkg::COL_ONE;
    assign row_last = row_ff == crs_pkg::SENSOR_ROWS - crs_pkg::COL_ONE;
    assign roi_last = !roi_ff.en ? (col_last && row_last)
        : ({1'b0, row_ff} == row_end - 12'h1 && (dual_ff ? col_last
        : {1'b0, col_ff} == {1'b0, roi_ff.col_start} + {1'b0, roi_ff.col_count} - 12'h1));
    // Every frame ends via RO_DONE, then idle, after the whole array: shifting out leaves it empty
    assign nxt_after = col_last ? (row_last ? crs_pkg::RO_DONE : crs_pkg::RO_ROW)
        : crs_pkg::RO_PIX;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ro_ff <= crs_pkg::RO_IDLE;
        end else if (clk_en) begin
            case (ro_ff)
                crs_pkg::RO_IDLE: begin
                    if (ro_start) begin
                        ro_ff <= sensor_interline ? crs_pkg::RO_XFER : crs_pkg::RO_ROW;
                    end
                end
                crs_pkg::RO_XFER: if (ro_tick) ro_ff <= crs_pkg::RO_ROW;
                crs_pkg::RO_ROW: if (ro_tick) ro_ff <= crs_pkg::RO_PIX;
                crs_pkg::RO_PIX: if (ro_tick) ro_ff <= px_hit ? crs_pkg::RO_DIG : nxt_after;
                crs_pkg::RO_DIG: if (ro_step) ro_ff <= nxt_after;
                crs_pkg::RO_DONE: ro_ff <= crs_pkg::RO_IDLE;
                default: ro_ff <= crs_pkg::RO_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_ff <= crs_pkg::CYC_ZERO;
        end else if (clk_en) begin
            if (ro_ff == crs_pkg::RO_IDLE || ro_ff == crs_pkg::RO_DONE || ro_step
                || (ro_tick && ro_ff != crs_pkg::RO_DIG)) begin
                cyc_ff <= crs_pkg::CYC_ZERO;
            end else if (!ro_tick) begin
                cyc_ff <= cyc_ff + 16'h1;
            end
        end
    end

    // Row advances only after the last column of the row has gone
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_ff <= 11'h0;
            row_ff <= 11'h0;
        end else if (clk_en) begin
            if (ro_start) begin
                col_ff <= 11'h0;
                row_ff <= 11'h0;
            end else if ((ro_ff == crs_pkg::RO_PIX && ro_tick && !px_hit) || (ro_ff == crs_pkg::RO_DIG && ro_step)) begin
                col_ff <= col_last ? 11'h0 : col_ff + crs_pkg::COL_ONE;
                row_ff <= col_last ? row_ff + crs_pkg::COL_ONE : row_ff;
            end
        end
    end

    // Region and port choice are frozen for the whole frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            roi_ff <= '0;
            dual_ff <= 1'b0;
            intl_ff <= 1'b0;
        end else if (clk_en && ro_start) begin
            roi_ff <= roi;
            dual_ff <= dual_ok;
            intl_ff <= sensor_interline;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sof_ff <= 1'b0;
        end else if (clk_en) begin
            if (ro_start) begin
                sof_ff <= 1'b1;
            end else if (push && buf_in_ready) begin
                // Cleared only when the buffer really took the word
                sof_ff <= 1'b0;
            end
        end
    end

    assign push = ro_ff == crs_pkg::RO_DIG && ro_tick;
    always_comb begin
        push_word.sof = sof_ff;
        push_word.eof = roi_last;
        push_word.sample_a = adc_sample_a;
        push_word.sample_b = dual_ff ? adc_sample_b : 16'h0;
    end

    // Receiver stall holds the sequencer in digitize, so no word is lost
    crs_pix_buf u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(push_word),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_data)
    );

    assign intensifier_gate = ex_ff == crs_pkg::EX_GATE;
    assign storage_xfer = ro_ff == crs_pkg::RO_XFER;
    assign row_shift = ro_ff == crs_pkg::RO_ROW;
    assign pixel_shift = ro_ff == crs_pkg::RO_PIX;
    assign pixel_digitize = ro_ff == crs_pkg::RO_DIG;
    assign dual_port_active = dual_ff;
    assign single_port_sel = crs_pkg::SINGLE_PORT_SEL;
    assign overlapped_mode = ovl_ff;
    assign frame_done = ro_ff == crs_pkg::RO_DONE;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_arm_ready;
        ex_ff == crs_pkg::EX_ARM && acq_enable && free_run && ex_permit;
    endsequence
    sequence s_ovl_ready;
        ex_ff == crs_pkg::EX_ARM && acq_enable && free_run && nxt_ovl
            && ro_ff != crs_pkg::RO_IDLE && ro_ff != crs_pkg::RO_XFER;
    endsequence
    sequence s_row_leave;
        (ro_ff == crs_pkg::RO_PIX || ro_ff == crs_pkg::RO_DIG) ##1 ro_ff == crs_pkg::RO_ROW;
    endsequence

    a_dual_select: assert property (ro_start |=> dual_port_active == $past(dual_ok))
        else $error("port mode not taken from region at frame start");
    a_variant_single: assert property (ro_start && variant_single_port |=> !dual_port_active)
        else $error("single-port variant went dual");
    a_port_fixed: assert property (##1 $stable(single_port_sel))
        else $error("single port selection changed");
    a_ovl_select: assert property (ex_go && !nxt_ovl |=> !overlapped_mode)
        else $error("overlap kept with short exposure");
    a_gate_quiet: assert property (intensifier_gate && !overlapped_mode |-> ro_ff == crs_pkg::RO_IDLE)
        else $error("gate opened during non-overlapped readout");
    a_ovl_start: assert property (s_ovl_ready |=> intensifier_gate)
        else $error("overlapped exposure did not start during readout");
    a_freerun_go: assert property (ro_ff == crs_pkg::RO_DONE ##1 s_arm_ready |=> intensifier_gate)
        else $error("free-run did not restart after frame done");
    a_sync_wait: assert property (ex_ff == crs_pkg::EX_ARM && !free_run && !ext_sync && !sync_pend_ff
        |=> !intensifier_gate)
        else $error("exposure started without sync");
    a_first_step: assert property (ro_start |=> storage_xfer == intl_ff && row_shift != intl_ff)
        else $error("wrong first readout step for sensor type");
    a_row_order: assert property (s_row_leave |-> $past(col_last) && col_ff == 11'h000)
        else $error("row shifted before row finished");
    a_skip_outside: assert property (ro_ff == crs_pkg::RO_PIX && ro_tick && !px_hit |=> !pixel_digitize)
        else $error("pixel outside region was digitized");
    a_done_pulse: assert property (frame_done |=> !frame_done && ro_ff == crs_pkg::RO_IDLE)
        else $error("frame done not a single pulse");
endmodule

// ===== testbench.sv
// Self-checking bench for the CCD readout sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, clk_en, acq_enable, free_run, ext_sync, sensor_interline, variant_single_port;
    logic stall, intensifier_gate, storage_xfer, row_shift, pixel_shift, pixel_digitize;
    logic dual_port_active, single_port_sel, overlapped_mode, frame_done, pix_valid, pix_ready;
    logic ps_q, dg_q, gate_ro, mon_clr;
    logic [15:0] adc_sample_a, adc_sample_b;
    logic [31:0] readout_cycles, frame_cycles, words, sof_seen, eof_seen, bad_words;
    logic [31:0] ps_cnt, dg_cnt, xf_cnt, first_ro, w0;
    crs_pkg::crs_roi_t roi;
    crs_pkg::crs_timing_t timing;
    crs_pkg::crs_pix_t pix_data;
    int err_count = 0;
    int checks_done = 0;

    crs_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .acq_enable(acq_enable),
        .free_run(free_run), .ext_sync(ext_sync), .sensor_interline(sensor_interline),
        .variant_single_port(variant_single_port), .roi(roi), .timing(timing), .adc_sample_a(adc_sample_a),
        .adc_sample_b(adc_sample_b), .intensifier_gate(intensifier_gate), .storage_xfer(storage_xfer),
        .row_shift(row_shift), .pixel_shift(pixel_shift), .pixel_digitize(pixel_digitize),
        .dual_port_active(dual_port_active), .single_port_sel(single_port_sel),
        .overlapped_mode(overlapped_mode), .frame_done(frame_done), .readout_cycles(readout_cycles),
        .frame_cycles(frame_cycles), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data));

    crs_sensor_model sensor (.sys_clk(sys_clk), .rst_n(rst_n), .pixel_digitize(pixel_digitize),
        .dual(dual_port_active), .stall(stall), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .adc_sample_a(adc_sample_a), .adc_sample_b(adc_sample_b), .words(words),
        .sof_seen(sof_seen), .eof_seen(eof_seen), .bad_words(bad_words));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Activity monitor, cleared by the bench before each frame whose counts it checks
    always @(posedge sys_clk) begin
        ps_q <= pixel_shift;
        dg_q <= pixel_digitize;
        if (mon_clr) begin
            ps_cnt <= 32'h0;
            dg_cnt <= 32'h0;
            xf_cnt <= 32'h0;
            first_ro <= 32'h0;
            gate_ro <= 1'b0;
        end else begin
            if (pixel_shift && !ps_q) ps_cnt <= ps_cnt + 32'h1;
            if (pixel_digitize && !dg_q) dg_cnt <= dg_cnt + 32'h1;
            if (storage_xfer) xf_cnt <= xf_cnt + 32'h1;
            if (first_ro == 32'h0 && storage_xfer) first_ro <= 32'h1;
            if (first_ro == 32'h0 && row_shift && !storage_xfer) first_ro <= 32'h2;
            if (intensifier_gate && (row_shift || pixel_shift || pixel_digitize)) gate_ro <= 1'b1;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cfg(input logic en, input logic [10:0] cs, input logic il, input logic var1, input logic [23:0] ex);
        @(negedge sys_clk);
        // Off-centre or centred windows of width 8 only
        roi = '{en: en, col_start: cs, col_count: 11'h008, row_start: 11'h000, row_count: 11'h002};
        timing = '{pixel_shift_duration: 8'h02, digitize: 8'h03, row_shift: 8'h01, exposure: ex, decay: 16'h0005};
        sensor_interline = il;
        variant_single_port = var1;
    endtask

    task automatic clear_mon();
        @(negedge sys_clk);
        mon_clr = 1'b1;
        w0 = words;
        @(negedge sys_clk);
        mon_clr = 1'b0;
    endtask

    task automatic sync_pulse();
        @(negedge sys_clk);
        ext_sync = 1'b1;
        @(negedge sys_clk);
        ext_sync = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (frame_done !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        check("frame done seen", 32'(n < 20000), 32'h1);
        n = 0;
        while (pix_valid !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic restart_within(input int lim);
        int n;
        n = 0;
        while (intensifier_gate !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        check("prompt restart", 32'(n < lim), 32'h1);
    endtask

    task automatic t_reset();
        check("gate at reset", 32'(intensifier_gate), 32'h0);
        check("done at reset", 32'(frame_done), 32'h0);
        check("valid at reset", 32'(pix_valid), 32'h0);
        check("fixed port", 32'(single_port_sel), 32'(crs_pkg::SINGLE_PORT_SEL));
    endtask

    task automatic t_estimate();
        cfg(1'b1, 11'h000, 1'b1, 1'b0, 24'h00000A);
        repeat (3) @(negedge sys_clk);
        check("single estimate", readout_cycles, 32'(16 * (2 + 3) + 2 * 1));
        check("frame estimate", frame_cycles, 32'(16 * (2 + 3) + 2 * 1 + 10 + 5));
        cfg(1'b1, 11'h00C, 1'b1, 1'b0, 24'h00000A);
        repeat (3) @(negedge sys_clk);
        check("dual estimate", readout_cycles, 32'(8 * (2 + 3) + 2 * 1));
    endtask

    task automatic t_nonoverlap();
        int n;
        cfg(1'b1, 11'h000, 1'b1, 1'b0, 24'h00000A);
        clear_mon();
        stall = 1'b1;
        acq_enable = 1'b1;
        sync_pulse();
        wait_done();
        check("non-overlapped", 32'(overlapped_mode), 32'h0);
        check("gate off in readout", 32'(gate_ro), 32'h0);
        check("transfer first", first_ro, 32'h1);
        check("digitized", dg_cnt, 32'd16);
        check("discards shifted", 32'(ps_cnt > 32'd16), 32'h1);
        check("words", words - w0, 32'd16);
        check("word order", bad_words, 32'h0);
        check("frame marks", sof_seen + eof_seen, 32'h2);
        check("single port", 32'(dual_port_active), 32'h0);
        n = 0;
        repeat (20) begin
            @(negedge sys_clk);
            n += int'(intensifier_gate === 1'b1);
        end
        check("waits for sync", 32'(n), 32'h0);
    endtask

    task automatic t_sync_freerun();
        sync_pulse();
        check("sync starts", 32'(intensifier_gate), 32'h1);
        free_run = 1'b1;
        wait_done();
        restart_within(4);
        free_run = 1'b0;
        wait_done();
    endtask

    task automatic t_fullframe();
        cfg(1'b1, 11'h00C, 1'b0, 1'b0, 24'h00000A);
        clear_mon();
        stall = 1'b0;
        sync_pulse();
        free_run = 1'b1;
        wait_done();
        check("row shift first", first_ro, 32'h2);
        check("no transfer", xf_cnt, 32'h0);
        check("dual port", 32'(dual_port_active), 32'h1);
        check("dual words", words - w0, 32'd8);
        check("dual order", bad_words, 32'h0);
        restart_within(4);
        free_run = 1'b0;
        wait_done();
    endtask

    task automatic t_overlap();
        cfg(1'b1, 11'h000, 1'b1, 1'b0, 24'h0000C8);
        free_run = 1'b1;
        sync_pulse();
        wait_done();
        clear_mon();
        wait_done();
        check("overlapped", 32'(overlapped_mode), 32'h1);
        check("exposure during readout", 32'(gate_ro), 32'h1);
        free_run = 1'b0;
        wait_done();
    endtask

    task automatic port_probe(input logic en, input logic [10:0] cs, input logic var1, input logic exp);
        int n;
        cfg(en, cs, 1'b0, var1, 24'h00000A);
        rst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        sync_pulse();
        n = 0;
        while (row_shift !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check("port mode", 32'(dual_port_active), 32'(exp));
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        acq_enable = 1'b0;
        free_run = 1'b0;
        ext_sync = 1'b0;
        stall = 1'b0;
        sensor_interline = 1'b1;
        variant_single_port = 1'b0;
        roi = '0;
        timing = '0;
        clear_mon();
        repeat (6) @(negedge sys_clk);
        t_reset();
        rst_n = 1'b1;
        t_estimate();
        t_nonoverlap();
        t_sync_freerun();
        t_fullframe();
        t_overlap();
        port_probe(1'b0, 11'h000, 1'b0, 1'b1);
        port_probe(1'b1, 11'h00C, 1'b1, 1'b0);
        summarize();
    end
endmodule
